/* hdl/fer_regs.svh */
// register offsets, reset values and scaling constants of the readback bank
`ifndef FER_REGS_SVH
`define FER_REGS_SVH
`define FER_ADDR_W        12
`define FER_OFS_BEMF_D    12'h742
`define FER_OFS_BEMF_Q    12'h744
`define FER_OFS_SPEED     12'h752
`define FER_OFS_ANGLE     12'h756
`define FER_OFS_MAX_SPEED 12'h760
`define FER_RST_WORD      32'h00000000
`define FER_RST_MAX_SPEED 32'h00000000
`define FER_FRAC_BITS     27
`define FER_CYCLES_RD     1
`endif

/* hdl/fer_pkg.sv */
// types shared by the estimator readback bank
package fer_pkg;
  typedef logic [31:0] fer_word_t;
  typedef enum logic [2:0] {
    FER_SEL_NONE  = 3'b000,
    FER_SEL_BEMFD = 3'b001,
    FER_SEL_BEMFQ = 3'b010,
    FER_SEL_SPEED = 3'b011,
    FER_SEL_ANGLE = 3'b100,
    FER_SEL_MAXSP = 3'b101
  } fer_sel_t;
endpackage

/* hdl/fer_est_if.sv */
// carrier between the bank top and its word store
`timescale 1ns/1ps
interface fer_est_if;
  import fer_pkg::*;
  logic      wr_en;    // estimator update strobe
  fer_sel_t  wr_sel;   // word being updated
  fer_word_t wr_data;  // new estimate
  logic      rd_en;    // read strobe
  fer_sel_t  rd_sel;   // word being read
  fer_word_t rd_data;  // registered read word
  modport top   (output wr_en, wr_sel, wr_data, rd_en, rd_sel,
                 input rd_data);
  modport store (input wr_en, wr_sel, wr_data, rd_en, rd_sel,
                 output rd_data);
endinterface

/* hdl/fer_word_store.sv */
// holds the four estimate words; read data leave from a register
`timescale 1ns/1ps
`include "fer_regs.svh"
module fer_word_store
  import fer_pkg::*;
(
  input wire logic clock,  // core clock
  input wire logic rst,    // synchronous reset, active high
  fer_est_if.store bus     // update and read side
);
  typedef struct packed {
    fer_word_t [3:0] word;
    fer_word_t       rd;
  } fer_store_t;
  fer_store_t s_q;
  fer_store_t s_d;

  // update one word per strobe; read always samples the stored value
  always_comb begin
    s_d = s_q;
    if (bus.wr_en && bus.wr_sel != FER_SEL_NONE &&
        bus.wr_sel != FER_SEL_MAXSP) begin
      s_d.word[2'(bus.wr_sel - FER_SEL_BEMFD)] = bus.wr_data;
    end
    if (bus.rd_en && bus.rd_sel != FER_SEL_NONE &&
        bus.rd_sel != FER_SEL_MAXSP) begin
      s_d.rd = s_q.word[2'(bus.rd_sel - FER_SEL_BEMFD)];
    end else begin
      s_d.rd = `FER_RST_WORD;
    end
  end

  // every word clears to zero until the estimator first writes it
  always_ff @(posedge clock) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.rd_data = s_q.rd;
endmodule

/* hdl/fer_readback.sv */
// estimator readback register bank with plain register port
`timescale 1ns/1ps
`include "fer_regs.svh"
module fer_readback
  import fer_pkg::*;
#(
  parameter int ADDR_W = `FER_ADDR_W  // register address width
) (
  input  wire logic              clock,      // core clock, 250 MHz
  input  wire logic              rst,        // sync reset, active high
  input  wire logic [ADDR_W-1:0] addr,       // register address
  input  wire logic [31:0]       wdata,      // write data
  input  wire logic              wr,         // write strobe
  input  wire logic              rd,         // read strobe
  output logic      [31:0]       rdata,      // read data, cycle after rd
  input  wire logic              est_valid,  // estimator update strobe
  input  wire logic [31:0]       est_bemf_d, // new d-axis back-emf
  input  wire logic [31:0]       est_bemf_q, // new q-axis back-emf
  input  wire logic [31:0]       est_speed,  // new speed, unit max speed
  input  wire logic [31:0]       est_angle,  // new angle, unit 360 deg
  output logic      [31:0]       max_speed   // stored max speed, hz
);
  localparam int FRAC = `FER_FRAC_BITS; // binary point of every word

  fer_est_if est ();

  typedef struct packed {
    logic [1:0]  upd_idx;   // word being copied into the store
    logic        upd_busy;  // copy of one estimator sample in progress
    fer_word_t [3:0] snap;  // sample held while copying
    logic        rd_store;  // previous read went to the store
    logic        rd_maxsp;  // previous read hit the max speed word
    fer_word_t   maxsp;     // configured maximum speed
    fer_word_t   rd_maxw;   // max speed read word, zero otherwise
  } fer_top_t;
  fer_top_t t_q;
  fer_top_t t_d;

  // address decode shared by read and write paths
  function automatic fer_sel_t decode(input logic [ADDR_W-1:0] a);
    unique case (a)
      ADDR_W'(`FER_OFS_BEMF_D):    decode = FER_SEL_BEMFD;
      ADDR_W'(`FER_OFS_BEMF_Q):    decode = FER_SEL_BEMFQ;
      ADDR_W'(`FER_OFS_SPEED):     decode = FER_SEL_SPEED;
      ADDR_W'(`FER_OFS_ANGLE):     decode = FER_SEL_ANGLE;
      ADDR_W'(`FER_OFS_MAX_SPEED): decode = FER_SEL_MAXSP;
      default:                     decode = FER_SEL_NONE;
    endcase
  endfunction

  fer_sel_t rsel;
  fer_sel_t wsel;
  assign rsel = rd ? decode(addr) : FER_SEL_NONE;
  assign wsel = wr ? decode(addr) : FER_SEL_NONE;

  // the store takes one word per cycle, so a sample is copied over four
  // cycles; a new sample arriving mid-copy is dropped, trading freshness
  // for a single write port
  always_comb begin
    t_d = t_q;
    if (est_valid && !t_q.upd_busy) begin
      t_d.snap[0]  = est_bemf_d;
      t_d.snap[1]  = est_bemf_q;
      t_d.snap[2]  = est_speed;
      t_d.snap[3]  = est_angle;
      t_d.upd_busy = 1'b1;
      t_d.upd_idx  = 2'h0;
    end else if (t_q.upd_busy) begin
      t_d.upd_idx  = t_q.upd_idx + 2'h1;
      t_d.upd_busy = (t_q.upd_idx != 2'h3);
    end
    // software writes to the estimate words are ignored
    if (wsel == FER_SEL_MAXSP) begin
      t_d.maxsp = wdata;
    end
    t_d.rd_store = (rsel != FER_SEL_NONE) && (rsel != FER_SEL_MAXSP);
    t_d.rd_maxsp = (rsel == FER_SEL_MAXSP);
    t_d.rd_maxw  = (rsel == FER_SEL_MAXSP) ? t_q.maxsp : `FER_RST_WORD;
  end

  // store update port and read port
  assign est.wr_en   = t_q.upd_busy;
  assign est.wr_sel  = fer_sel_t'(3'(t_q.upd_idx) + 3'h1);
  assign est.wr_data = t_q.snap[t_q.upd_idx];
  assign est.rd_en   = (rsel != FER_SEL_NONE);
  assign est.rd_sel  = rsel;

  always_ff @(posedge clock) begin
    if (rst) begin
      t_q       <= '0;
      t_q.maxsp <= `FER_RST_MAX_SPEED;
    end else begin
      t_q <= t_d;
    end
  end

  fer_word_store u_store (
    .clock (clock),
    .rst   (rst),
    .bus   (est)
  );

  // both read registers are zero unless their own word was read, so an
  // or merges them without a second register stage and its extra cycle
  assign rdata = est.rd_data | t_q.rd_maxw;

  // the speed scale factor leaves straight from its register
  always_ff @(posedge clock) begin
    if (rst) begin
      max_speed <= `FER_RST_MAX_SPEED;
    end else begin
      max_speed <= t_d.maxsp;
    end
  end

  // FRAC only documents the binary point; the bank never rescales words
  logic unused_frac;
  assign unused_frac = (FRAC == 0);
endmodule

/* tb/fer_readback_sva.sv */
// concurrent checks on the estimator readback bank ports
`timescale 1ns/1ps
`include "fer_regs.svh"
module fer_readback_sva
  import fer_pkg::*;
#(
  parameter int ADDR_W = `FER_ADDR_W  // address width
) (
  input wire logic              clock,      // core clock
  input wire logic              rst,        // sync reset
  input wire logic [ADDR_W-1:0] addr,       // address
  input wire logic [31:0]       wdata,      // write data
  input wire logic              wr,         // write strobe
  input wire logic              rd,         // read strobe
  input wire logic [31:0]       rdata,      // read data
  input wire logic              est_valid,  // update strobe
  input wire logic [31:0]       est_bemf_d, // d-emf
  input wire logic [31:0]       est_bemf_q, // q-emf
  input wire logic [31:0]       est_speed,  // speed
  input wire logic [31:0]       est_angle,  // angle
  input wire logic [31:0]       max_speed   // max speed
);
  // low until the first update after reset, so reads must show zero
  logic seen_q;
  always_ff @(posedge clock) seen_q <= rst ? 1'b0 : (seen_q | est_valid);
  // an update is taken only 5 edges after the last one taken; its words
  // are all in place once since_q reaches 5 again
  logic [2:0]  since_q;
  logic [31:0] cap_d, cap_q, cap_s, cap_a;
  always_ff @(posedge clock) begin
    if (rst) begin
      since_q <= 3'h7;
      {cap_d, cap_q, cap_s, cap_a} <= '0;
    end else if (est_valid && since_q >= 3'h5) begin
      since_q <= 3'h1;
      {cap_d, cap_q, cap_s, cap_a} <=
        {est_bemf_d, est_bemf_q, est_speed, est_angle};
    end else begin
      since_q <= (since_q == 3'h7) ? 3'h7 : since_q + 3'h1;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  AST_EMF_D: assert property (
    since_q >= 3'h5 && rd && addr == `FER_OFS_BEMF_D
    |=> rdata == $past(cap_d)) else $error("d-emf read wrong");
  AST_EMF_Q: assert property (
    since_q >= 3'h5 && rd && addr == `FER_OFS_BEMF_Q
    |=> rdata == $past(cap_q)) else $error("q-emf read wrong");
  AST_SPEED: assert property (
    since_q >= 3'h5 && rd && addr == `FER_OFS_SPEED
    |=> rdata == $past(cap_s)) else $error("speed read wrong");
  AST_ANGLE: assert property (
    since_q >= 3'h5 && rd && addr == `FER_OFS_ANGLE
    |=> rdata == $past(cap_a)) else $error("angle read wrong");
  AST_ZERO: assert property (
    !seen_q && !est_valid && rd && addr inside {`FER_OFS_BEMF_Q,
    `FER_OFS_SPEED, `FER_OFS_ANGLE} |=> rdata == '0)
    else $error("word not zero before update");
  AST_D_ZERO: assert property (
    !seen_q && !est_valid && rd && addr == `FER_OFS_BEMF_D
    |=> rdata == '0) else $error("d-emf not zero before update");
  // a write squeezed between two reads must not move the word
  AST_READ_ONLY: assert property (
    since_q >= 3'h5 && rd && addr == `FER_OFS_SPEED && !est_valid
    ##1 !est_valid
    ##1 rd && addr == `FER_OFS_SPEED && !est_valid
    |=> rdata == $past(rdata, 2)) else $error("speed word was written");
  AST_MAX_SPEED: assert property (
    wr && addr == `FER_OFS_MAX_SPEED |=> max_speed == $past(wdata))
    else $error("max speed not stored");
endmodule
bind fer_readback fer_readback_sva #(.ADDR_W(ADDR_W)) i_sva (.*);

/* tb/fer_readback_test.sv */
// self-checking bench for the estimator readback bank
`timescale 1ns/1ps
`include "fer_regs.svh"
module fer_readback_test;
  import fer_pkg::*;
  logic        clock = 0, rst = 1, wr = 0, rd = 0, est_valid = 0, rd_q = 0;
  logic [11:0] addr = '0;
  logic [31:0] wdata = '0, est_bemf_d = '0, est_bemf_q = '0;
  logic [31:0] est_speed = '0, est_angle = '0, rdata, max_speed, w[4];
  logic [11:0] ofs[4] = '{`FER_OFS_BEMF_D, `FER_OFS_BEMF_Q, `FER_OFS_SPEED,
                          `FER_OFS_ANGLE};
  fer_word_t   exp_q[$];
  int          n_errors = 0, n_checks = 0, seed;
  always #2 clock = ~clock;
  fer_readback i_dut (.*);
  // one bus cycle; every signal set each call so none is driven twice
  task automatic bus(input logic w_, r_, input logic [11:0] a,
                     input logic [31:0] d, input fer_word_t e);
    wr <= w_;
    rd <= r_;
    addr <= a;
    wdata <= d;
    if (r_) exp_q.push_back(e);
    @(posedge clock);
  endtask
  // one estimator update pulse carrying w; the bank copies it over four
  // more cycles, so the bus stays idle until every word has landed
  task automatic upd;
    {est_bemf_d, est_bemf_q, est_speed, est_angle} <= {w[0], w[1], w[2], w[3]};
    est_valid <= 1'b1;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clock);
    est_valid <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
  // back-to-back reads of all four words
  task automatic rd_all(input logic z);
    for (int i = 0; i < 4; i++) bus(0, 1, ofs[i], '0, z ? '0 : w[i]);
  endtask
  task automatic summarize;
    $display("errors %0d checks %0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // read data stand only in the cycle after the strobe
  always @(posedge clock) begin
    if (rd_q) begin
      n_checks++;
      if (exp_q.size() == 0 || rdata !== exp_q.pop_front()) begin
        n_errors++;
        $display("MISMATCH %0t read data %h", $time, rdata);
      end
    end
    rd_q <= rd;
  end
  // second pass is a reset in mid-run
  initial begin
    seed = $urandom(32'h6BF2CCD8);
    for (int k = 0; k < 2; k++) begin
      bus(0, 0, '0, '0, '0);
      rst <= 1'b1;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      rd_all(1);
      foreach (w[i]) w[i] = $urandom;
      for (int i = 0; i < 4; i++) bus(1, 0, ofs[i], w[i], '0);
      rd_all(1);
      upd();
      rd_all(0);
      bus(0, 1, `FER_OFS_SPEED, '0, w[2]);
      bus(1, 0, `FER_OFS_SPEED, ~w[2], '0);
      bus(0, 1, `FER_OFS_SPEED, '0, w[2]);
      bus(1, 0, `FER_OFS_MAX_SPEED, w[0], '0);
      bus(0, 1, `FER_OFS_MAX_SPEED, '0, w[0]);
      n_checks++;
      if (max_speed !== w[0]) begin
        n_errors++;
        $display("MISMATCH %0t max speed %h", $time, max_speed);
      end
      w = '{default: 32'h08000000};
      upd();
      rd_all(0);
    end
    bus(0, 0, '0, '0, '0);
    repeat (2) @(posedge clock);
    summarize();
  end
  // the run needs under a hundred cycles
  initial begin
    repeat (2000) @(posedge clock);
    n_errors++;
    summarize();
  end
endmodule
